// ---- hw/pvm_regs.sv ----
`timescale 1ns/1ps
`include "pvm_map.svh"
// Notes on behaviour
// - Next page disable bit stops automatic exchange
// - When disabled, advertise only advertisement next-page bit
// - Energy bit shows line energy, one at reset
// - Software reset clears energy, flags if set
// - Bit zero enables semi crossover, resets zero
// - Early receive-valid enable in 10BASE-T
// - Bit fourteen disables 10BASE-T half duplex loopback
// - Bit seven picks CRC counter receive/transmit source
// - Read-only bit shows MAC clock rate
// - Station address from straps, seeds scrambler
// - FIFO depth field gives four to seven bytes
// - Manual crossover select for channels zero, one
// - Manual crossover select for channels two, three
// - Bit zero selects conditional parallel detect
// - Crossover disable bit hands pins to manual
module pvm_regs
  import pvm_pkg::*;
#(
  parameter int SYNC_STAGES = 2              // Pin synchroniser depth
) (
  input  wire logic      core_clk_i,         // Core clock, 125 MHz
  input  wire logic      rst_n_i,            // Hardware reset, sync, low
  input  wire logic      soft_rst_i,         // Software reset pulse
  input  wire logic      reg_wr_i,           // Register write strobe
  input  wire logic      reg_rd_i,           // Register read strobe
  input  wire pvm_addr_t reg_addr_i,         // Register index
  input  wire pvm_word_t reg_wdata_i,        // Write data
  output pvm_word_t      reg_rdata_o,        // Read data, next cycle
  input  wire logic      line_energy_i,      // Line energy detector (async)
  input  wire logic      mac_clk_25_i,       // MAC clock at 25 MHz (async)
  input  wire pvm_addr_t addr_strap_i,       // Address strap pins (async)
  input  wire pvm_mode_t mode_strap_i,       // Mode strap pins (async)
  input  wire logic      adv_next_page_i,    // Advertisement next page bit
  input  wire logic      auto_x01_i,         // Automatic crossover, ch 0/1
  input  wire logic      auto_x23_i,         // Automatic crossover, ch 2/3
  output logic           energy_change_set_o,// Energy change flag set pulse
  output logic           auto_np_disable_o,  // Automatic next page stopped
  output logic           next_page_adv_o,    // Next pages advertised
  output logic           semi_xover_en_o,    // Semi crossover enable
  output logic           auto_xover_dis_o,   // Automatic crossover disabled
  output logic           mdix_01_o,          // Crossed pins, channels 0/1
  output logic           mdix_23_o,          // Crossed pins, channels 2/3
  output logic           rxdv_early_o,       // Early receive-valid enable
  output logic           hd_lb_disable_o,    // Half duplex loopback off
  output logic           crc_src_tx_o,       // CRC counter on transmit data
  output pvm_addr_t      station_address_o,  // Management/scrambler address
  output pvm_mode_t      operating_mode_o,   // Operating mode field
  output logic [2:0]     tx_fifo_depth_o,    // Transmit FIFO depth, bytes
  output logic           cond_pd_o           // Conditional parallel detect
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (SYNC_STAGES < 2 || SYNC_STAGES > 6) begin : g_bad_sync
    $error("SYNC_STAGES must be 2 to 6");
  end

  localparam int SW = 2 + 2 * $bits(pvm_addr_t);   // Synchronised bit count
  localparam logic [2:0] STRAP_WAIT = 3'(SYNC_STAGES + 1);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SW-1:0] sync_q [SYNC_STAGES];  // Shift chain, stage 0 first
  logic [SW-1:0] pins_s;                // Last stage, safe to read
  // Shift all pin inputs through the chain
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_q[i] <= {`PVM_ENERGY_RST, {(SW-1){1'b0}}};  // Energy idles high, no false rise
      end
    end else begin
      sync_q[0] <= {line_energy_i, mac_clk_25_i, addr_strap_i, mode_strap_i};
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_q[i] <= sync_q[i-1];
      end
    end
  end
  assign pins_s = sync_q[SYNC_STAGES-1];
  logic      energy_s;   // Synchronised line energy
  logic      mclk_s;     // Synchronised MAC clock rate
  pvm_addr_t addr_s;     // Synchronised address strap
  pvm_mode_t mode_s;     // Synchronised mode strap
  assign {energy_s, mclk_s, addr_s, mode_s} = pins_s;

  // ****************************************************************
  // Write decode
  // ****************************************************************
  logic wr_en;   // Write to energy/crossover register
  logic wr_sm;   // Write to special modes register
  logic wr_ex;   // Write to extended mode register
  // Software reset wins over a write in the same cycle
  assign wr_en = reg_wr_i && !soft_rst_i && (reg_addr_i == `PVM_IDX_ENERGY);
  assign wr_sm = reg_wr_i && !soft_rst_i && (reg_addr_i == `PVM_IDX_SPECIAL);
  assign wr_ex = reg_wr_i && !soft_rst_i && (reg_addr_i == `PVM_IDX_EXTENDED);
  // ****************************************************************
  // Energy and crossover register
  // ****************************************************************
  logic axdis_q;    // Automatic crossover disable
  logic npdis_q;    // Automatic next page disable
  logic semi_q;     // Semi crossover enable
  logic energy_q;   // Line energy indicator
  logic chg_q;      // Energy change set pulse
  // Control bits, cleared by either reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || soft_rst_i) begin
      axdis_q <= 1'b0;
      npdis_q <= 1'b0;
      semi_q  <= 1'b0;
    end else if (wr_en) begin
      axdis_q <= reg_wdata_i[`PVM_EN_AXDIS_BIT];
      npdis_q <= reg_wdata_i[`PVM_EN_NPDIS_BIT];
      semi_q  <= reg_wdata_i[`PVM_EN_SEMI_BIT];
    end
  end

  // Energy indicator: one after hardware reset, zero after software reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      energy_q <= `PVM_ENERGY_RST;
      chg_q    <= 1'b0;
    end else if (soft_rst_i) begin
      energy_q <= 1'b0;
      chg_q    <= energy_q;
    end else begin
      energy_q <= energy_s;
      chg_q    <= energy_s && !energy_q;
    end
  end

  // ****************************************************************
  // Special and extended mode registers
  // ****************************************************************
  logic       early_q;   // Early receive-valid enable
  logic       lbdis_q;   // Half duplex loopback disable (kept on soft reset)
  logic       crcsrc_q;  // CRC counter source
  pvm_addr_t  addr_q;    // Station address (kept on soft reset)
  pvm_mode_t  mode_q;    // Operating mode (kept on soft reset)
  logic [1:0] fifo_q;    // Transmit FIFO depth code
  logic       x01_q;     // Manual crossover, channels 0/1
  logic       x23_q;     // Manual crossover, channels 2/3
  logic       cpd_q;     // Conditional parallel detect
  logic [2:0] strap_cnt_q;  // Wait for straps to pass the synchroniser
  // Soft-resettable mode bits
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || soft_rst_i) begin
      early_q  <= 1'b0;
      crcsrc_q <= 1'b0;
      fifo_q   <= `PVM_FIFO_RST;
      x01_q    <= 1'b0;
      x23_q    <= 1'b0;
      cpd_q    <= 1'b0;
    end else begin
      if (wr_sm) begin
        early_q  <= reg_wdata_i[`PVM_SM_EARLY_BIT];
        crcsrc_q <= reg_wdata_i[`PVM_SM_CRCSRC_BIT];
      end
      if (wr_ex) begin
        fifo_q <= reg_wdata_i[`PVM_EX_FIFO_MSB:`PVM_EX_FIFO_LSB];
        x01_q  <= reg_wdata_i[`PVM_EX_X01_BIT];
        x23_q  <= reg_wdata_i[`PVM_EX_X23_BIT];
        cpd_q  <= reg_wdata_i[`PVM_EX_CPD_BIT];
      end
    end
  end

  // Strap-loaded fields and loopback disable, untouched by software reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strap_cnt_q <= STRAP_WAIT;
      lbdis_q     <= 1'b0;
      addr_q      <= '0;
      mode_q      <= '0;
    end else if (strap_cnt_q != 3'h0) begin
      // Straps settle through the synchroniser, then load once
      strap_cnt_q <= strap_cnt_q - 3'h1;
      if (strap_cnt_q == 3'h1) begin
        addr_q <= addr_s;
        mode_q <= mode_s;
      end
    end else begin
      if (wr_sm) begin
        lbdis_q <= reg_wdata_i[`PVM_SM_LBDIS_BIT];
        addr_q  <= reg_wdata_i[`PVM_SM_ADDR_MSB:`PVM_SM_ADDR_LSB];
      end
      if (wr_ex) begin
        mode_q <= reg_wdata_i[`PVM_EX_MODE_MSB:`PVM_EX_MODE_LSB];
      end
    end
  end

  // ****************************************************************
  // Registered outputs to the PHY core
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      next_page_adv_o <= 1'b1;
      mdix_01_o       <= 1'b0;
      mdix_23_o       <= 1'b0;
    end else begin
      next_page_adv_o <= npdis_q ? adv_next_page_i : 1'b1;
      mdix_01_o       <= axdis_q ? x01_q : auto_x01_i;
      mdix_23_o       <= axdis_q ? x23_q : auto_x23_i;
    end
  end

  assign energy_change_set_o = chg_q;
  assign auto_np_disable_o   = npdis_q;
  assign semi_xover_en_o     = semi_q;
  assign auto_xover_dis_o    = axdis_q;
  assign rxdv_early_o        = early_q;
  assign hd_lb_disable_o     = lbdis_q;
  assign crc_src_tx_o        = crcsrc_q;
  assign station_address_o   = addr_q;
  assign operating_mode_o    = mode_q;
  assign tx_fifo_depth_o     = `PVM_FIFO_BASE + {1'b0, fifo_q};
  assign cond_pd_o           = cpd_q;

  // ****************************************************************
  // Read path, reserved bits read as zero
  // ****************************************************************
  pvm_word_t rd_word;   // Selected register image
  // Assemble the addressed register
  always_comb begin
    rd_word = `PVM_RDATA_ZERO;
    unique case (reg_addr_i)
      `PVM_IDX_ENERGY: begin
        rd_word[`PVM_EN_AXDIS_BIT]  = axdis_q;
        rd_word[`PVM_EN_NPDIS_BIT]  = npdis_q;
        rd_word[`PVM_EN_ENERGY_BIT] = energy_q;
        rd_word[`PVM_EN_SEMI_BIT]   = semi_q;
      end
      `PVM_IDX_SPECIAL: begin
        rd_word[`PVM_SM_EARLY_BIT]  = early_q;
        rd_word[`PVM_SM_LBDIS_BIT]  = lbdis_q;
        rd_word[`PVM_SM_CRCSRC_BIT] = crcsrc_q;
        rd_word[`PVM_SM_MCLK_BIT]   = mclk_s;
        rd_word[`PVM_SM_ADDR_MSB:`PVM_SM_ADDR_LSB] = addr_q;
      end
      `PVM_IDX_EXTENDED: begin
        rd_word[`PVM_EX_MODE_MSB:`PVM_EX_MODE_LSB] = mode_q;
        rd_word[`PVM_EX_FIFO_MSB:`PVM_EX_FIFO_LSB] = fifo_q;
        rd_word[`PVM_EX_X01_BIT] = x01_q;
        rd_word[`PVM_EX_X23_BIT] = x23_q;
        rd_word[`PVM_EX_CPD_BIT] = cpd_q;
      end
      default: rd_word = `PVM_RDATA_ZERO;
    endcase
  end

  // Capture read data one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `PVM_RDATA_ZERO;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_word;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  np_disable_a: assert property (wr_en && !soft_rst_i |=>
    auto_np_disable_o == $past(reg_wdata_i[`PVM_EN_NPDIS_BIT]))
    else $error("next page disable not stored");
  np_adv_a: assert property (auto_np_disable_o && !adv_next_page_i |=>
    !next_page_adv_o) else $error("next page advertised while disabled");
  energy_sw_a: assert property (soft_rst_i && energy_q |=>
    !energy_q && energy_change_set_o) else $error("soft reset energy wrong");
  semi_a: assert property (soft_rst_i |=> !semi_xover_en_o)
    else $error("semi crossover not cleared");
  early_a: assert property (wr_sm && !soft_rst_i |=>
    rxdv_early_o == $past(reg_wdata_i[`PVM_SM_EARLY_BIT]))
    else $error("early receive-valid not stored");
  lb_keep_a: assert property (soft_rst_i && strap_cnt_q == 3'h0 |=>
    $stable(hd_lb_disable_o) && $stable(station_address_o))
    else $error("strap fields lost on soft reset");
  mclk_rd_a: assert property (reg_rd_i && reg_addr_i == `PVM_IDX_SPECIAL |=>
    reg_rdata_o[`PVM_SM_MCLK_BIT] == $past(mclk_s)) else $error("clock rate read wrong");
  fifo_a: assert property (wr_ex |=> tx_fifo_depth_o ==
    `PVM_FIFO_BASE + 3'($past(reg_wdata_i[`PVM_EX_FIFO_MSB:`PVM_EX_FIFO_LSB])))
    else $error("fifo depth wrong");
  xover_a: assert property (auto_xover_dis_o && $stable(x01_q) |=>
    mdix_01_o == $past(x01_q)) else $error("manual crossover ignored");
  xover23_a: assert property (!auto_xover_dis_o |=>
    mdix_23_o == $past(auto_x23_i)) else $error("automatic crossover ignored");
  energy_rise_c: cover property (!energy_q ##1 energy_q ##1 energy_change_set_o);
  soft_energy_c: cover property (energy_q && soft_rst_i);
  manual_x_c:    cover property (wr_en && reg_wdata_i[`PVM_EN_AXDIS_BIT]);
  strap_load_c:  cover property (strap_cnt_q == 3'h1 ##1 strap_cnt_q == 3'h0);
endmodule

// ---- hw/pvm_map.svh ----
`ifndef PVM_MAP_SVH
`define PVM_MAP_SVH

// ****************************************************************
// Register indices on the management port
// ****************************************************************
`define PVM_IDX_ENERGY      5'h11
`define PVM_IDX_SPECIAL     5'h12
`define PVM_IDX_EXTENDED    5'h13

// ****************************************************************
// Energy and crossover status fields
// ****************************************************************
`define PVM_EN_AXDIS_BIT    5
`define PVM_EN_NPDIS_BIT    4
`define PVM_EN_ENERGY_BIT   1
`define PVM_EN_SEMI_BIT     0

// ****************************************************************
// Special modes fields
// ****************************************************************
`define PVM_SM_EARLY_BIT    15
`define PVM_SM_LBDIS_BIT    14
`define PVM_SM_CRCSRC_BIT   7
`define PVM_SM_MCLK_BIT     6
`define PVM_SM_ADDR_MSB     4
`define PVM_SM_ADDR_LSB     0

// ****************************************************************
// Extended mode fields
// ****************************************************************
`define PVM_EX_MODE_MSB     15
`define PVM_EX_MODE_LSB     11
`define PVM_EX_FIFO_MSB     10
`define PVM_EX_FIFO_LSB     9
`define PVM_EX_X01_BIT      2
`define PVM_EX_X23_BIT      1
`define PVM_EX_CPD_BIT      0

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define PVM_ENERGY_RST      1'b1
`define PVM_FIFO_RST        2'h0
`define PVM_FIFO_BASE       3'h4
`define PVM_RDATA_ZERO      16'h0000

`endif

// ---- hw/pvm_pkg.sv ----
package pvm_pkg;
  typedef logic [4:0]  pvm_addr_t;   // Station address / register index
  typedef logic [4:0]  pvm_mode_t;   // Operating mode field
  typedef logic [15:0] pvm_word_t;   // Register data word
endpackage

// ---- test/pvm_mgmt_model.sv ----
`timescale 1ns/1ps
`include "pvm_map.svh"
// ****
// Management controller model
// ****
module pvm_mgmt_model
  import pvm_pkg::*;
(
  input  wire logic      core_clk_i,          // Core clock
  input  wire pvm_word_t reg_rdata_i,         // Read data from block
  input  wire logic      energy_change_set_i, // Flag set pulse
  output logic           reg_wr_o,            // Write strobe
  output logic           reg_rd_o,            // Read strobe
  output pvm_addr_t      reg_addr_o,          // Register index
  output pvm_word_t      reg_wdata_o          // Write data
);
  logic energy_change_flag; // Flag held on this side

  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 5'h00;
    reg_wdata_o = 16'h0000;
    energy_change_flag = 1'b0;
  end

  // Set the flag on each pulse from the block
  always @(posedge core_clk_i) begin
    if (energy_change_set_i === 1'b1) begin
      energy_change_flag = 1'b1;
    end
  end

  // Released lines show the inverse so stale values never look valid
  task automatic release_bus();
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask

  // One write, taken at the next edge
  task automatic wr(input pvm_addr_t addr, input pvm_word_t data);
    @(posedge core_clk_i);
    #1;
    reg_wr_o = 1'b1;
    reg_addr_o = addr;
    reg_wdata_o = data;
    @(posedge core_clk_i);
    #1;
    release_bus();
  endtask

  // One read, data registered at the taking edge
  task automatic rd(input pvm_addr_t addr, output pvm_word_t data);
    @(posedge core_clk_i);
    #1;
    reg_rd_o = 1'b1;
    reg_addr_o = addr;
    @(posedge core_clk_i);
    #1;
    data = reg_rdata_i;
    release_bus();
  endtask

  // Mode field carried over, reserved bits written as zero
  task automatic wr_ext(input logic [2:0] low, input logic [1:0] depth);
    pvm_word_t cur;
    rd(`PVM_IDX_EXTENDED, cur);
    wr(`PVM_IDX_EXTENDED, {cur[15:11], depth, 6'h00, low});
  endtask

  // Clears the flag held on this side, no register write
  task automatic clear_flag();
    energy_change_flag = 1'b0;
  endtask
endmodule

// ---- test/phy_vendor_mode_registers_tb.sv ----
`timescale 1ns/1ps
`include "pvm_map.svh"
module phy_vendor_mode_registers_tb
  import pvm_pkg::*;
();
  logic      core_clk, rst_n, soft_rst, reg_wr, reg_rd, line_energy, mac_clk_25;
  logic      adv_np, auto_x01, auto_x23, set_pulse, np_dis, np_adv, semi, ax_dis;
  logic      mdix_01, mdix_23, rx_early, lb_dis, crc_tx, cond_pd;
  pvm_addr_t reg_addr, addr_strap, st_addr;
  pvm_mode_t mode_strap, op_mode;
  pvm_word_t reg_wdata, reg_rdata, rd_data;
  logic [2:0] depth;
  int        fail_count = 0;  // Mismatches seen
  int        check_count = 0; // Comparisons made

  pvm_regs i_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .soft_rst_i(soft_rst),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .line_energy_i(line_energy), .mac_clk_25_i(mac_clk_25),
    .addr_strap_i(addr_strap), .mode_strap_i(mode_strap), .adv_next_page_i(adv_np),
    .auto_x01_i(auto_x01), .auto_x23_i(auto_x23), .energy_change_set_o(set_pulse),
    .auto_np_disable_o(np_dis), .next_page_adv_o(np_adv), .semi_xover_en_o(semi),
    .auto_xover_dis_o(ax_dis), .mdix_01_o(mdix_01), .mdix_23_o(mdix_23),
    .rxdv_early_o(rx_early), .hd_lb_disable_o(lb_dis), .crc_src_tx_o(crc_tx),
    .station_address_o(st_addr), .operating_mode_o(op_mode), .tx_fifo_depth_o(depth),
    .cond_pd_o(cond_pd));

  pvm_mgmt_model i_mgmt (.core_clk_i(core_clk), .reg_rdata_i(reg_rdata),
    .energy_change_set_i(set_pulse), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

  // Free running 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ****
  // Helpers
  // ****
  task automatic chk_w(input pvm_word_t got, input pvm_word_t exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single bits go through the word compare
  task automatic chk_b(input logic got, input logic exp);
    chk_w({15'h0000, got}, {15'h0000, exp});
  endtask

  // Reads a register and compares the whole word
  task automatic rd_chk(input pvm_addr_t addr, input pvm_word_t exp);
    i_mgmt.rd(addr, rd_data);
    chk_w(rd_data, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic soft_pulse();
    cyc(1);
    soft_rst = 1'b1;
    cyc(1);
    soft_rst = 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cuts a hung run short
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    wrap_up();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    {rst_n, soft_rst, adv_np, auto_x01} = 4'h0;
    {line_energy, mac_clk_25, auto_x23} = 3'h7;
    addr_strap = 5'h15;
    mode_strap = 5'h0B;
    cyc(16);
    rst_n = 1'b1;
    cyc(4);
    // Reset image with straps loaded
    chk_b(np_adv, 1'b1);
    chk_w(16'(depth), 16'h0004);
    chk_w(16'(st_addr), 16'h0015);
    chk_w(16'(op_mode), 16'h000B);
    chk_b(i_mgmt.energy_change_flag, 1'b0);
    rd_chk(`PVM_IDX_ENERGY, 16'h0002);
    rd_chk(`PVM_IDX_SPECIAL, 16'h0055);
    rd_chk(`PVM_IDX_EXTENDED, 16'h5800);
    // Energy register: writable bits only, read-only bit untouched
    i_mgmt.wr(`PVM_IDX_ENERGY, 16'hFFFF);
    rd_chk(`PVM_IDX_ENERGY, 16'h0033);
    chk_b(np_dis, 1'b1);
    chk_b(semi, 1'b1);
    chk_b(ax_dis, 1'b1);
    chk_b(np_adv, 1'b0);
    adv_np = 1'b1;
    cyc(2);
    chk_b(np_adv, 1'b1);
    // Every depth code and manual pin choice, automatic inputs opposite
    for (int i = 0; i < 4; i++) begin
      auto_x01 = ~i[1];
      auto_x23 = ~i[0];
      i_mgmt.wr_ext({i[1], i[0], i[0]}, i[1:0]);
      cyc(1);
      chk_w(16'(depth), 16'(i + 4));
      chk_b(mdix_01, i[1]);
      chk_b(mdix_23, i[0]);
      chk_b(cond_pd, i[0]);
    end
    rd_chk(`PVM_IDX_EXTENDED, 16'h5E07);
    i_mgmt.wr(`PVM_IDX_ENERGY, 16'h0000);
    cyc(1);
    chk_b(mdix_01, auto_x01);
    chk_b(mdix_23, auto_x23);
    chk_b(np_dis, 1'b0);
    // Special modes, read-only clock bit not writable
    mac_clk_25 = 1'b0;
    cyc(4);
    i_mgmt.wr(`PVM_IDX_SPECIAL, 16'hFFCA);
    rd_chk(`PVM_IDX_SPECIAL, 16'hC08A);
    chk_b(rx_early, 1'b1);
    chk_b(lb_dis, 1'b1);
    chk_b(crc_tx, 1'b1);
    chk_w(16'(st_addr), 16'h000A);
    mac_clk_25 = 1'b1;
    cyc(4);
    rd_chk(`PVM_IDX_SPECIAL, 16'hC0CA);
    // Unmapped index ignores writes and reads zero
    i_mgmt.wr(5'h10, 16'hFFFF);
    rd_chk(5'h10, 16'h0000);
    // Soft reset with energy present raises the flag
    i_mgmt.clear_flag();
    i_mgmt.wr(`PVM_IDX_ENERGY, 16'h0031);
    soft_pulse();
    cyc(2);
    chk_b(i_mgmt.energy_change_flag, 1'b1);
    i_mgmt.rd(`PVM_IDX_ENERGY, rd_data);
    chk_w(rd_data & 16'hFFFD, 16'h0000);
    rd_chk(`PVM_IDX_SPECIAL, 16'h404A);
    rd_chk(`PVM_IDX_EXTENDED, 16'h5800);
    // Soft reset with no energy leaves the flag clear
    i_mgmt.clear_flag();
    line_energy = 1'b0;
    cyc(5);
    soft_pulse();
    cyc(2);
    chk_b(i_mgmt.energy_change_flag, 1'b0);
    line_energy = 1'b1;
    cyc(6);
    chk_b(i_mgmt.energy_change_flag, 1'b1);
    rd_chk(`PVM_IDX_ENERGY, 16'h0002);
    wrap_up();
  end
endmodule
